// *** estop_ctrl_model.sv ***
// outside control circuit: stop contact, reset button, other inputs
`timescale 1ns/1ps
module estop_ctrl_model(input wire clk_i, open_i, rst_i,
  output wire [7:0] contact_o);
  reg [5:0] r = 6'h00;
  // unused contacts wander so nothing leans on their level
  always @(negedge clk_i) r <= $urandom;
  // open_i stands for an open, unwired or broken stop line
  assign contact_o = {r[5:1], !open_i, r[0], rst_i};
endmodule // estop_ctrl_model

// *** estop_io_defs.vh ***
// constants shared by the terminal function and emergency stop logic
`ifndef ESTOP_IO_DEFS_VH
`define ESTOP_IO_DEFS_VH
`define OC_FUNC_COUNT      6'd51
`define RELAY_FUNC_COUNT   6'd43
`define FUNC_SEL_W         6
`define OC_OUT_COUNT       5
`define TH_OHM_W           14
`define TH_OHM_MAX         14'd9999
`define TH_OHM_RESET       14'd3000
`define ALARM_CODE_OFF     2'd0
`define ALARM_CODE_3BIT    2'd1
`define ALARM_CODE_4BIT    2'd2
`define RELAY_FUNC_ALARM   6'h05
`define ESTOP_TRIP_CODE    4'he
`define TH_TRIP_CODE       4'h9
`define POL_NO             1'b0
`define POL_NC             1'b1
`endif

// *** estop_io_logic.v ***
// terminal output mapping, thermistor trip and hardware emergency stop
`timescale 1ns/1ps
`include "estop_io_defs.vh"
module estop_io_logic
  (
  input  wire        CORE_CLK_I,
  input  wire        RST_B_I,
  input  wire        ESTOP_ENABLE_SWITCH_I,
  input  wire [7:0]  CONTACT_IN_I,
  input  wire [7:0]  IN_POLARITY_I,
  input  wire [7:0]  IN_FUNC_RESET_MASK_I,
  input  wire [63:0] STATUS_FUNCS_I,
  input  wire [29:0] OC_FUNC_SEL_I,
  input  wire [5:0]  RELAY_FUNC_SEL_I,
  input  wire [1:0]  ALARM_CODE_OUTPUT_SETTING_I,
  input  wire [3:0]  ALARM_CAUSE_I,
  input  wire        PROTECT_TRIP_I,
  input  wire [13:0] THERMISTOR_OHM_I,
  input  wire [13:0] TH_THRESHOLD_I,
  input  wire        TH_THRESHOLD_WE_I,
  input  wire        KEYPAD_RELEASE_I,
  input  wire        SW_GATE_EN_I,
  output reg  [4:0]  OC_OUT_O,
  output reg         RELAY_OUT_O,
  output reg         GATE_ENABLE_O,
  output reg         ESTOP_TRIP_O,
  output reg         TH_TRIP_O,
  output reg  [3:0]  TRIP_CODE_O,
  output reg         DRIVE_RESET_O,
  output reg  [7:0]  INPUT_FUNC_ACTIVE_O,
  output reg  [13:0] TH_THRESHOLD_O
  );

  reg  [13:0] th_thr_r;
  reg         estop_r;
  reg         th_trip_r;
  wire [7:0]  in_logic;
  wire [4:0]  oc_sel;
  wire        relay_sel;
  wire        reset_in;
  wire        stop_in;
  wire        estop_en;
  reg  [4:0]  oc_nxt;
  reg  [7:0]  pol_eff;
  integer     k;

  // overview of the data paths in this block:
  //  - reset and stop contact levels are folded through a per-input polarity so
  //    that a logic one means asserted; the mapped reset inputs use raw levels
  //  - with the stop switch on, input one is the trip reset and input
  //    three the stop line; their polarities are pinned, not configurable
  //  - the stop line is wired normally closed, so a cut or missing wire
  //    reads the same as a pressed stop button and trips the drive
  //  - the gate enable is cut straight from the stop input as well as
  //    from the latch, so the halt never waits on the latch update
  //  - every top-level output is registered, which costs one cycle of
  //    latency but keeps glitches off the pins
  // limitation: contact inputs are taken as already synchronous and
  // debounced; a bouncing reset contact simply releases a little early

  // the switch is a plain level; the factory position is off
  assign estop_en = ESTOP_ENABLE_SWITCH_I;

  // polarity of inputs one and three is pinned while the stop is enabled
  always @*
  begin
    pol_eff = IN_POLARITY_I;
    if (estop_en)
    begin
      pol_eff[0] = `POL_NO;
      pol_eff[2] = `POL_NC;
    end
  end

  assign in_logic = CONTACT_IN_I ^ pol_eff;
  assign reset_in = in_logic[0];
  // nc contact: open wire reads as logic one, i.e. stop commanded
  assign stop_in  = estop_en & in_logic[2];

  // output function catalogue selection
  // each status output owns one six-bit select; a select beyond the
  // catalogue end gives a quiet output instead of an undefined one
  genvar g;
  generate
    for (g = 0; g < 5; g = g + 1)
    begin : oc_map
      func_select u_sel
        (
        .status_i (STATUS_FUNCS_I),
        .sel_i    (OC_FUNC_SEL_I[g*6 +: 6]),
        .count_i  (`OC_FUNC_COUNT),
        .out_o    (oc_sel[g])
        );
    end
  endgenerate

  func_select u_relay
    (
    .status_i (STATUS_FUNCS_I),
    .sel_i    (RELAY_FUNC_SEL_I),
    .count_i  (`RELAY_FUNC_COUNT),
    .out_o    (relay_sel)
    );

  // alarm code mode overrides the first three or four outputs
  // the code is taken from the registered trip code so that the outputs
  // show the same cause that the trip code port reports
  always @*
  begin
    oc_nxt = oc_sel;
    if (ALARM_CODE_OUTPUT_SETTING_I == `ALARM_CODE_3BIT)
      oc_nxt[2:0] = TRIP_CODE_O[2:0];
    else if (ALARM_CODE_OUTPUT_SETTING_I == `ALARM_CODE_4BIT)
      oc_nxt[3:0] = TRIP_CODE_O;
  end

  // threshold register, writes above range are clipped
  always @(posedge CORE_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
      th_thr_r <= `TH_OHM_RESET;
    else if (TH_THRESHOLD_WE_I)
      th_thr_r <= (TH_THRESHOLD_I > `TH_OHM_MAX) ?
                  `TH_OHM_MAX : TH_THRESHOLD_I;
  end

  // trip latches; set wins over a release in the same cycle
  // hazard: holding the reset contact closed while the stop line is
  // still open must not let the drive run, hence the set priority
  // the keypad may release a thermistor trip only while no emergency
  // stop is latched; the emergency trip itself answers to input one only
  always @(posedge CORE_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      estop_r   <= 1'b0;
      th_trip_r <= 1'b0;
    end
    else
    begin
      if (stop_in)
        estop_r <= 1'b1;
      else if (reset_in)
        estop_r <= 1'b0;
      if (THERMISTOR_OHM_I >= th_thr_r)
        th_trip_r <= 1'b1;
      else if (reset_in || (KEYPAD_RELEASE_I && !estop_r))
        th_trip_r <= 1'b0;
    end
  end

  // registered outputs; the gate path ignores software when stopped
  // trip code priority: emergency stop first, then thermistor, then the
  // cause handed in from the rest of the drive
  // the reset output follows input one when the stop is enabled and the
  // mapped reset inputs otherwise
  always @(posedge CORE_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      OC_OUT_O            <= 5'h00;
      RELAY_OUT_O         <= 1'b0;
      GATE_ENABLE_O       <= 1'b0;
      ESTOP_TRIP_O        <= 1'b0;
      TH_TRIP_O           <= 1'b0;
      TRIP_CODE_O         <= 4'h0;
      DRIVE_RESET_O       <= 1'b0;
      INPUT_FUNC_ACTIVE_O <= 8'hff;
      TH_THRESHOLD_O      <= `TH_OHM_RESET;
    end
    else
    begin
      OC_OUT_O      <= oc_nxt;
      // default relay function reports any protection halt
      RELAY_OUT_O   <= (RELAY_FUNC_SEL_I == `RELAY_FUNC_ALARM) ?
                       (PROTECT_TRIP_I | estop_r | th_trip_r) :
                       relay_sel;
      // stop input cuts the gate directly, not waiting on the latch
      GATE_ENABLE_O <= SW_GATE_EN_I & ~stop_in & ~estop_r &
                       ~th_trip_r;
      ESTOP_TRIP_O  <= estop_r;
      TH_TRIP_O     <= th_trip_r;
      TRIP_CODE_O   <= estop_r ? `ESTOP_TRIP_CODE :
                       th_trip_r ? `TH_TRIP_CODE :
                       ALARM_CAUSE_I;
      DRIVE_RESET_O <= estop_en ? reset_in :
                       |(CONTACT_IN_I & IN_FUNC_RESET_MASK_I);
      for (k = 0; k < 8; k = k + 1)
        INPUT_FUNC_ACTIVE_O[k] <= ~(estop_en && (k == 0 || k == 2));
      TH_THRESHOLD_O <= th_thr_r;
    end
  end

  // note: nothing here remembers the switch history; turning the switch
  // off hands inputs one and three back at once

endmodule // estop_io_logic

// *** estop_io_logic_asserts.sv ***
// port checker for the emergency stop io block
`timescale 1ns/1ps
module estop_io_logic_asserts(input wire CORE_CLK_I, RST_B_I,
  ESTOP_ENABLE_SWITCH_I, TH_THRESHOLD_WE_I, GATE_ENABLE_O, ESTOP_TRIP_O,
  TH_TRIP_O, input wire [7:0] CONTACT_IN_I, INPUT_FUNC_ACTIVE_O,
  input wire [13:0] THERMISTOR_OHM_I, TH_THRESHOLD_I, TH_THRESHOLD_O,
  input wire [3:0] TRIP_CODE_O);
  wire sw = ESTOP_ENABLE_SWITCH_I;
  wire t  = ESTOP_TRIP_O;
  wire r0 = CONTACT_IN_I[0];
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_B_I);
  // release only counts while the stop contact stays closed: set wins
  sequence stp; sw && !CONTACT_IN_I[2]; endsequence
  sequence clr; sw && r0 && CONTACT_IN_I[2] ##1 (sw && CONTACT_IN_I[2]) [*2];
  endsequence
  gate_cut_a: assert property (stp |=> !GATE_ENABLE_O)
    else $error("gate left on");
  trip_set_a: assert property (stp |-> ##2 t)
    else $error("no stop trip");
  trip_code_a: assert property (t |-> TRIP_CODE_O == 4'he)
    else $error("wrong trip code");
  trip_hold_a: assert property (t && sw && !$past(r0) |=> t)
    else $error("trip dropped");
  trip_clear_a: assert property (clr |-> !t)
    else $error("trip not cleared");
  func_mask_a: assert property (
    sw |=> (INPUT_FUNC_ACTIVE_O & 8'h05) == 8'h00) else $error("input free");
  th_clip_a: assert property (TH_THRESHOLD_WE_I |-> ##2 TH_THRESHOLD_O ==
    ($past(TH_THRESHOLD_I, 2) > 14'd9999 ? 14'd9999 :
    $past(TH_THRESHOLD_I, 2)))
    else $error("threshold wrong");
  th_trip_a: assert property (
    !$past(TH_THRESHOLD_WE_I) && THERMISTOR_OHM_I >= TH_THRESHOLD_O
    |-> ##2 TH_TRIP_O)
    else $error("no thermistor trip");
endmodule // estop_io_logic_asserts
bind estop_io_logic estop_io_logic_asserts chk(.*);

// *** estop_io_logic_tb.sv ***
// self-checking bench for the emergency stop io block
`timescale 1ns/1ps
`include "estop_io_defs.vh"
module estop_io_logic_tb;
  reg clk = 0, rstn = 0, sw = 0, we = 0, kp = 0, op = 0, rq = 0;
  reg [7:0] pol = 0;
  reg [63:0] st = 0;
  reg [29:0] sel = 0;
  reg [5:0] rs = 0;
  reg [1:0] md = 0;
  reg pt = 0;
  wire drst;
  reg [3:0] cause = 0;
  reg [13:0] ohm = 0, thr = 0, x;
  wire [7:0] ci, act;
  wire [4:0] oc;
  wire [3:0] code;
  wire [13:0] tho;
  wire rl, gate, et, tt;
  integer fails = 0, compares = 0, i;
  estop_ctrl_model ctl(.clk_i(clk), .open_i(op), .rst_i(rq), .contact_o(ci));
  estop_io_logic uut(.CORE_CLK_I(clk), .RST_B_I(rstn),
    .ESTOP_ENABLE_SWITCH_I(sw), .CONTACT_IN_I(ci), .IN_POLARITY_I(pol),
    .IN_FUNC_RESET_MASK_I(8'h00), .STATUS_FUNCS_I(st), .OC_FUNC_SEL_I(sel),
    .RELAY_FUNC_SEL_I(rs), .ALARM_CODE_OUTPUT_SETTING_I(md),
    .ALARM_CAUSE_I(cause), .PROTECT_TRIP_I(pt), .THERMISTOR_OHM_I(ohm),
    .TH_THRESHOLD_I(thr), .TH_THRESHOLD_WE_I(we), .KEYPAD_RELEASE_I(kp),
    .SW_GATE_EN_I(1'b1), .OC_OUT_O(oc), .RELAY_OUT_O(rl),
    .GATE_ENABLE_O(gate), .ESTOP_TRIP_O(et), .TH_TRIP_O(tt),
    .TRIP_CODE_O(code), .DRIVE_RESET_O(drst), .INPUT_FUNC_ACTIVE_O(act),
    .TH_THRESHOLD_O(tho));
  initial forever #10 clk = ~clk;
  // selects past the catalogue end read as zero
  // alarm code modes put the cause on the first three or four outputs
  function [4:0] oc_exp(input [63:0] s, input [29:0] q, input [1:0] m,
    input [3:0] c);
    integer k;
    begin
      for (k = 0; k < 5; k = k + 1)
        oc_exp[k] = q[k*6+:6] < `OC_FUNC_COUNT ? s[q[k*6+:6]] : 1'b0;
      if (m == `ALARM_CODE_3BIT)
        oc_exp[2:0] = c[2:0];
      else if (m == `ALARM_CODE_4BIT)
        oc_exp[3:0] = c;
    end
  endfunction
  task chk(input [39:0] n, input [15:0] s, e);
    begin
      compares = compares + 1;
      if (s !== e)
      begin
        fails = fails + 1;
        $display("BAD %s exp %h seen %h", n, e, s);
      end
    end
  endtask
  task finish_test;
    begin
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  task step(input integer n);
    repeat (n) @(negedge clk);
  endtask
  // whole run is about 140 cycles
  initial
  begin
    #200000 fails = fails + 1;
    finish_test;
  end
  initial
  begin
    i = $urandom(25256);
    step(4);
    rstn = 1;
    step(1);
    chk("thr", tho, `TH_OHM_RESET);
    for (i = 0; i < 30; i = i + 1)
    begin
      st = {$urandom, $urandom};
      sel = $urandom;
      rs = (i % 8 == 0) ? `RELAY_FUNC_ALARM : $urandom;
      cause = $urandom;
      md = $urandom;
      pt = $urandom;
      step(2);
      chk("oc", oc, oc_exp(st, sel, md, cause));
      chk("relay", rl, rs == `RELAY_FUNC_ALARM ? pt :
        (rs < `RELAY_FUNC_COUNT ? st[rs] : 1'b0));
    end
    md = 0;
    pt = 0;
    // stop line broken with the switch still off
    op = 1;
    pol = 8'hff;
    step(5);
    chk("off", et, 0);
    sw = 1;
    step(5);
    chk("trip", et, 1);
    chk("code", code, `ESTOP_TRIP_CODE);
    chk("gate", gate, 0);
    chk("act", act & 8'h05, 0);
    op = 0;
    kp = 1;
    step(5);
    chk("hold", et, 1);
    kp = 0;
    rq = 1;
    step(1);
    chk("drst", drst, 1);
    rq = 0;
    step(4);
    chk("clr", et, 0);
    chk("run", gate, 1);
    // threshold clip, then trip only once the threshold is reached
    for (i = 0; i < 6; i = i + 1)
    begin
      thr = i[0] ? 14'h3fff : $urandom % 9999 + 1;
      x = thr > `TH_OHM_MAX ? `TH_OHM_MAX : thr;
      we = 1;
      step(1);
      we = 0;
      ohm = x - i[1];
      step(4);
      chk("thr", tho, x);
      chk("th", tt, !i[1]);
      ohm = 0;
      kp = 1;
      step(1);
      kp = 0;
      step(3);
    end
    finish_test;
  end
endmodule // estop_io_logic_tb

// *** func_select.v ***
// picks one status signal out of the output function catalogue
`timescale 1ns/1ps
module func_select
  (
  input  wire [63:0] status_i,
  input  wire [5:0]  sel_i,
  input  wire [5:0]  count_i,
  output wire        out_o
  );

  // selections past the catalogue end read as no function
  assign out_o = (sel_i < count_i) ? status_i[sel_i] : 1'b0;

endmodule // func_select
